// ==== fsp_top.sv ====
`include "fsp_defs.svh"
`default_nettype none
module fsp_top import fsp_pkg::*; #(
  parameter int unsigned TACH_GATE_CYC = `FSP_TACH_GATE_MS * `FSP_CLK_KHZ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Temperatures in degrees C, from sensor logic on pclk
  input wire logic [6:0] cpu_temp,
  input wire logic [6:0] sys_temp,
  // Fan pins
  input wire logic fan_tach,
  output logic fan_pwm
);
  fsp_cfg_t cfg_r; // Software settings
  logic [31:0] prdata_r; // Read data, loaded in setup
  logic pready_r; // One access cycle per transfer
  logic pslverr_r; // Unmapped address flag
  logic [6:0] duty_r; // Applied duty
  logic [6:0] duty_nxt; // Target duty
  logic fan_on_r; // Auto-mode run state
  logic fan_on_nxt;
  logic pwm_r; // Registered pin drive
  logic [6:0] pwm_cnt_r; // Slot within PWM period
  logic [7:0] div_r; // Slot prescaler
  logic slot_en; // One-cycle slot tick
  logic [1:0] tach_sync_r; // Two-stage synchroniser
  logic tach_prev_r; // For edge detect
  logic tach_rise; // Rising tach edge, seen this cycle
  logic [31:0] gate_r; // Measurement window counter
  logic [15:0] edges_r; // Tach edges this window
  logic [15:0] rpm_r; // Last speed result
  logic [7:0] excess; // Degrees above start point, less the first degree
  logic [14:0] ramp; // Excess times 2^(slope-1), zero for slope 0
  logic [15:0] sum; // Start duty plus ramp
  logic wr_en; // Write takes effect
  logic setup; // APB setup cycle
  logic hit; // Address is mapped

  // Bus strobes: setup cycle and a write that lands on the pready edge
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_r && pwrite && !pslverr_r;

  // Address decode
  // Read-only words decode too, so reading them raises no error
  always_comb begin
    unique case (paddr)
      `FSP_OFS_MODE, `FSP_OFS_OFF_THR, `FSP_OFS_START_THR,
      `FSP_OFS_START_DUTY, `FSP_OFS_SLOPE, `FSP_OFS_MAN_DUTY,
      `FSP_OFS_STATUS, `FSP_OFS_TEMP, `FSP_OFS_RPM: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Handshake: zero wait states, answer is ready in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !hit;
    end
  end

  // Read data captured in setup so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= 32'h0000_0000;
      unique case (paddr)
        `FSP_OFS_MODE: prdata_r[1:0] <= cfg_r.mode;
        `FSP_OFS_OFF_THR: prdata_r[6:0] <= cfg_r.off_thr;
        `FSP_OFS_START_THR: prdata_r[6:0] <= cfg_r.start_thr;
        `FSP_OFS_START_DUTY: prdata_r[6:0] <= cfg_r.start_duty;
        `FSP_OFS_SLOPE: prdata_r[2:0] <= cfg_r.slope;
        `FSP_OFS_MAN_DUTY: prdata_r[6:0] <= cfg_r.man_duty;
        `FSP_OFS_STATUS: begin
          prdata_r[6:0] <= duty_r;
          prdata_r[`FSP_STAT_ON_BIT] <= fan_on_r;
        end
        `FSP_OFS_TEMP: begin
          prdata_r[6:0] <= cpu_temp;
          prdata_r[`FSP_TEMP_SYS_LSB +: 7] <= sys_temp;
        end
        `FSP_OFS_RPM: prdata_r[15:0] <= rpm_r;
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Settings; parameter writes are accepted in any mode and the
  // caller is trusted to change them only in the matching mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r.mode <= FSP_FULL;
      cfg_r.off_thr <= `FSP_RST_OFF_THR;
      cfg_r.start_thr <= `FSP_RST_START_THR;
      cfg_r.start_duty <= `FSP_RST_START_DUTY;
      cfg_r.slope <= `FSP_RST_SLOPE;
      cfg_r.man_duty <= `FSP_RST_MAN_DUTY;
    end else if (wr_en) begin
      unique case (paddr)
        `FSP_OFS_MODE: begin
          // Code 3 is illegal and falls back to the safe full-on mode
          if (pwdata[1:0] == FSP_AUTO) cfg_r.mode <= FSP_AUTO;
          else if (pwdata[1:0] == FSP_MAN) cfg_r.mode <= FSP_MAN;
          else cfg_r.mode <= FSP_FULL;
        end
        `FSP_OFS_OFF_THR: cfg_r.off_thr <= pwdata[6:0];
        `FSP_OFS_START_THR: cfg_r.start_thr <= pwdata[6:0];
        `FSP_OFS_START_DUTY: cfg_r.start_duty <= pwdata[6:0];
        `FSP_OFS_SLOPE: cfg_r.slope <= pwdata[2:0];
        `FSP_OFS_MAN_DUTY: cfg_r.man_duty <= pwdata[6:0];
        default: ;
      endcase
    end
  end

  // Auto run state with hysteresis between the two thresholds
  // Between the thresholds the fan keeps whatever state it had
  always_comb begin
    fan_on_nxt = fan_on_r;
    if (cfg_r.mode != FSP_AUTO) begin
      fan_on_nxt = 1'b1;
    end else if (cpu_temp <= cfg_r.off_thr) begin
      fan_on_nxt = 1'b0;
    end else if (cpu_temp > cfg_r.start_thr) begin
      fan_on_nxt = 1'b1;
    end
  end

  // Ramp: first degree past the start point gives the start duty
  // Compared at 8 bits so a start point of 127 cannot wrap to zero
  always_comb begin
    excess = 8'h00;
    if ({1'b0, cpu_temp} > {1'b0, cfg_r.start_thr} + 8'h01) begin
      excess = {1'b0, cpu_temp - cfg_r.start_thr - 7'h01};
    end
    // Code k gives 2^(k-1) steps per degree; code 0 holds the start duty
    // power-of-two slope
    if (cfg_r.slope == 3'h0) ramp = 15'h0000;
    else ramp = 15'({7'h00, excess} << (cfg_r.slope - 3'h1));
    sum = {9'h000, cfg_r.start_duty} + {1'b0, ramp};
  end

  // Target duty per mode
  always_comb begin
    unique case (cfg_r.mode)
      FSP_FULL: duty_nxt = `FSP_DUTY_MAX;
      FSP_AUTO: begin
        if (!fan_on_nxt) duty_nxt = 7'h00;
        else if (sum > {9'h000, `FSP_DUTY_MAX}) duty_nxt = `FSP_DUTY_MAX;
        else duty_nxt = sum[6:0];
      end
      FSP_MAN: duty_nxt = cfg_r.man_duty;
      default: duty_nxt = `FSP_DUTY_MAX;
    endcase
  end

  // Applied duty and run state
  // The extra stage keeps the ramp adder off the pin compare path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_r <= `FSP_DUTY_MAX;
      fan_on_r <= 1'b1;
    end else begin
      duty_r <= duty_nxt;
      fan_on_r <= fan_on_nxt;
    end
  end

  // Slot prescaler: 128 slots make one PWM period
  assign slot_en = (div_r == 8'(`FSP_PWM_DIV - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 8'h00;
      pwm_cnt_r <= 7'h00;
    end else if (slot_en) begin
      div_r <= 8'h00;
      pwm_cnt_r <= pwm_cnt_r + 7'h01;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // Pin drive; full-on holds the pin high with no low slot at all
  // Limitation: duty 127 still leaves one low slot in each period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_r <= 1'b1;
    end else if (cfg_r.mode == FSP_FULL) begin
      pwm_r <= 1'b1;
    end else begin
      pwm_r <= (pwm_cnt_r < duty_r);
    end
  end

  // Tach synchroniser; only the second stage feeds logic
  // Reset to the idle-high level so release does not fake an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tach_sync_r <= 2'b11;
      tach_prev_r <= 1'b1;
    end else begin
      tach_sync_r <= {tach_sync_r[0], fan_tach};
      tach_prev_r <= tach_sync_r[1];
    end
  end

  // A rising tach edge after the synchroniser
  assign tach_rise = tach_sync_r[1] && !tach_prev_r;

  // Limitation: the reading moves in steps of one edge per window
  // gated edge count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_r <= 32'h0000_0000;
      edges_r <= 16'h0000;
      rpm_r <= 16'h0000;
    end else if (gate_r == TACH_GATE_CYC - 1) begin
      gate_r <= 32'h0000_0000;
      // An edge on the window's last cycle opens the next count
      edges_r <= {15'h0000, tach_rise};
      rpm_r <= 16'(edges_r * `FSP_RPM_SCALE);
    end else begin
      gate_r <= gate_r + 32'h0000_0001;
      if (tach_rise && edges_r != 16'hffff) begin
        edges_r <= edges_r + 16'h0001;
      end
    end
  end

  // Every output comes straight from a flop
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign fan_pwm = pwm_r;

  // Checks run on pclk and rest while reset is low
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Checks on the rules that the block carries out
  a_full_pin_high: assert property (
    cfg_r.mode == FSP_FULL |=> fan_pwm) else $error("full-on pin dropped");
  a_auto_stop: assert property (
    cfg_r.mode == FSP_AUTO && cpu_temp <= cfg_r.off_thr |=> duty_r == 7'h00)
    else $error("fan not stopped below off threshold");
  a_off_cause: assert property (
    $fell(fan_on_r) |-> $past(cpu_temp) <= $past(cfg_r.off_thr))
    else $error("fan stopped above off threshold");
  a_start_cause: assert property (
    $rose(fan_on_r) && $past(cfg_r.mode) == FSP_AUTO
    |-> $past(cpu_temp) > $past(cfg_r.start_thr))
    else $error("fan started below start threshold");
  a_start_duty: assert property (
    cfg_r.mode == FSP_AUTO && fan_on_nxt && {1'b0, cpu_temp} <= {1'b0, cfg_r.start_thr} + 8'h01
    |=> duty_r == $past(cfg_r.start_duty)) else $error("wrong start duty");
  a_pwm_zero: assert property (
    cfg_r.mode != FSP_FULL && duty_r == 7'h00 && $past(duty_r) == 7'h00
    |=> !fan_pwm) else $error("pin high at zero duty");
  a_flat_slope: assert property (
    cfg_r.mode == FSP_AUTO && fan_on_nxt && cfg_r.slope == 3'h0
    |=> duty_r == $past(cfg_r.start_duty)) else $error("zero slope ramped");
  a_manual_duty: assert property (
    cfg_r.mode == FSP_MAN |=> duty_r == $past(cfg_r.man_duty))
    else $error("manual duty not applied");
  a_rpm_update: assert property (
    gate_r == TACH_GATE_CYC - 1 |=> rpm_r == 16'($past(edges_r) * `FSP_RPM_SCALE))
    else $error("speed not reported");
  a_no_wrap: assert property (
    cfg_r.mode == FSP_AUTO && fan_on_nxt |=> duty_r >= $past(cfg_r.start_duty))
    else $error("auto duty wrapped");

  // Main scenarios the tests should reach
  c_auto_stop: cover property ($fell(fan_on_r));
  c_auto_start: cover property ($rose(fan_on_r));
  c_saturate: cover property (cfg_r.mode == FSP_AUTO && duty_r == `FSP_DUTY_MAX);
  c_rpm: cover property (rpm_r != 16'h0000);
  c_manual: cover property (cfg_r.mode == FSP_MAN && duty_r == cfg_r.man_duty);
endmodule
`default_nettype wire

// ==== fsp_defs.svh ====
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
// Register byte offsets
`define FSP_OFS_MODE 12'h000
`define FSP_OFS_OFF_THR 12'h004
`define FSP_OFS_START_THR 12'h008
`define FSP_OFS_START_DUTY 12'h00c
`define FSP_OFS_SLOPE 12'h010
`define FSP_OFS_MAN_DUTY 12'h014
`define FSP_OFS_STATUS 12'h018
`define FSP_OFS_TEMP 12'h01c
`define FSP_OFS_RPM 12'h020
// Reset values
`define FSP_RST_OFF_THR 7'h00
`define FSP_RST_START_THR 7'h14
`define FSP_RST_START_DUTY 7'h46
`define FSP_RST_SLOPE 3'h1
`define FSP_RST_MAN_DUTY 7'h7f
// Duty range
`define FSP_DUTY_MAX 7'h7f
// Field positions
`define FSP_STAT_ON_BIT 8
`define FSP_TEMP_SYS_LSB 8
// Timing
`define FSP_CLK_KHZ 250000
`define FSP_PWM_FREQ_KHZ 25
`define FSP_PWM_DIV ((`FSP_CLK_KHZ) / ((`FSP_PWM_FREQ_KHZ) * 128))
`define FSP_TACH_GATE_MS 1000
`define FSP_TACH_PPR 2
`define FSP_RPM_SCALE (60000 / ((`FSP_TACH_GATE_MS) * (`FSP_TACH_PPR)))
`endif

// ==== fsp_pkg.sv ====
`default_nettype none
package fsp_pkg;
  // Fan operating modes
  typedef enum logic [1:0] {
    FSP_FULL = 2'b00,
    FSP_AUTO = 2'b01,
    FSP_MAN = 2'b10
  } fsp_mode_t;
  // Software settings travelling together
  typedef struct packed {
    fsp_mode_t mode;
    logic [6:0] off_thr;
    logic [6:0] start_thr;
    logic [6:0] start_duty;
    logic [2:0] slope;
    logic [6:0] man_duty;
  } fsp_cfg_t;
endpackage
`default_nettype wire

// ==== fsp_fan_model.sv ====
`default_nettype none
// Fan with tachometer: spins while driven, coasts briefly, then stops
module fsp_fan_model (
  // Clock
  input wire logic clk,
  // Fan drive and tachometer
  input wire logic drive,
  output logic tach = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // Fixed pulse rate keeps the expected speed reading exact
  localparam int HALF = 50;
  int idle = 0; // Cycles since drive was last high
  int phase = 0; // Position within one tach pulse
  // Tach idles high, as a pulled-up open-collector line would
  always @(posedge clk) begin
    idle <= drive ? 0 : idle + 1;
    phase <= (phase == 2 * HALF - 1) ? 0 : phase + 1;
    tach <= (idle < 20000) ? (phase < HALF) : 1'b1;
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`default_nettype none
module testbench import fsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PERIOD = 128 * 78; // One PWM period in clocks
  localparam logic [31:0] M7 = 32'h0000007f;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, fan_tach, fan_pwm;
  logic [6:0] cpu_temp = 7'h00;
  logic [6:0] sys_temp = 7'h21;
  int mismatches = 0;
  int n_compared = 0;
  int hi, x;
  logic [31:0] q;
  logic e;
  // Clock at 250 MHz
  always #2 pclk = ~pclk;
  fsp_top #(.TACH_GATE_CYC(1000)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_temp(cpu_temp), .sys_temp(sys_temp),
    .fan_tach(fan_tach), .fan_pwm(fan_pwm));
  fsp_fan_model fan (.clk(pclk), .drive(fan_pwm), .tach(fan_tach));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) mismatches++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] xv, input logic xe);
    apb(a, 1'b0, 32'h00000000);
    chk(nm, q & m, xv);
    chk("pslverr", {31'h0, e}, {31'h0, xe});
  endtask
  task automatic temp(input logic [6:0] t);
    @(posedge pclk);
    cpu_temp <= t;
    repeat (4) @(posedge pclk);
  endtask
  // High cycles over one PWM period, after the new duty has landed
  task automatic count_high();
    hi = 0;
    repeat (4) @(posedge pclk);
    repeat (PERIOD) begin
      @(negedge pclk);
      hi += (fan_pwm === 1'b1);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog: the tests need about 20k cycles, the limit is 50k
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd("rpm", 12'h020, ALL, 32'h0, 1'b0);
    rd("mode", 12'h000, ALL, 32'h0, 1'b0);
    rd("off_thr", 12'h004, ALL, 32'h0, 1'b0);
    rd("start_thr", 12'h008, ALL, 32'h14, 1'b0);
    rd("start_duty", 12'h00c, ALL, 32'h46, 1'b0);
    rd("unmapped", 12'h024, ALL, 32'h0, 1'b1);
    count_high();
    chk("full_high", hi, PERIOD);
    rd("rpm", 12'h020, ALL, 32'd300, 1'b0);
    // auto settings written in auto mode
    wr(12'h000, {30'h0, FSP_AUTO});
    rd("auto_off", 12'h018, 32'h100, 32'h0, 1'b0);
    temp(7'd21);
    rd("auto_start", 12'h018, 32'h17f, 32'h146, 1'b0);
    temp(7'd25);
    for (int k = 0; k < 8; k++) begin
      wr(12'h010, k);
      x = (k == 0) ? 70 : 70 + 4 * (1 << (k - 1));
      rd("auto_duty", 12'h018, M7, (x > 127) ? 127 : x, 1'b0);
    end
    temp(7'd15);
    rd("auto_hold", 12'h018, 32'h100, 32'h100, 1'b0);
    wr(12'h004, 32'h7f);
    rd("off_thr", 12'h004, ALL, 32'h7f, 1'b0);
    temp(7'd100);
    rd("auto_stop", 12'h018, 32'h100, 32'h0, 1'b0);
    wr(12'h004, 32'h0); // off threshold back to a safe low value
    rd("auto_restart", 12'h018, 32'h100, 32'h100, 1'b0);
    rd("temps", 12'h01c, ALL, 32'h2164, 1'b0);
    // manual duty written once manual mode is selected
    wr(12'h000, {30'h0, FSP_MAN});
    wr(12'h014, 32'd33);
    rd("mode_man", 12'h000, ALL, 32'h2, 1'b0);
    count_high();
    chk("man_high", hi, 33 * 78);
    wr(12'h000, 32'h3);
    rd("mode3", 12'h000, ALL, 32'h0, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
